/* File: src/sapreg_pkg.sv */
/*
 * Shared constants and types for the successive approximation register
 * stage and its result buffer.
 * Assumes a single 125 MHz clock and synchronous external inputs.
 */
package sapreg_pkg;

    localparam int WORD_W = 8;
    localparam int CLK_PERIOD_NS = 8;
    localparam logic [2:0] TOP_IDX = 3'h7;
    localparam logic [2:0] LOW_IDX = 3'h0;
    localparam logic [7:0] FIRST_TRIAL = 8'h80;
    localparam logic [7:0] BITS_RST = 8'h00;
    localparam logic [7:0] ONE_HOT_BASE = 8'h01;

    typedef enum logic [1:0] {
        SAPREG_IDLE = 2'h0,
        SAPREG_CONV = 2'h1,
        SAPREG_DONE = 2'h2
    } sapreg_state_t;

endpackage

/* File: src/sapreg_buf.sv */
/*
 * Two-entry result buffer with valid and ready on both sides.
 * Assumes the filler honours in_ready; the head entry drives the output.
 */
`timescale 1ns/10ps

module sapreg_buf
    import sapreg_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic in_valid, // Word offered by the filler.
    output logic in_ready, // Room for one more word.
    input wire logic [WORD_W-1:0] in_data, // Word to store.
    output logic out_valid, // Head entry holds a word.
    input wire logic out_ready, // Drain side accepts the head.
    output logic [WORD_W-1:0] out_data // Head word.
);

    logic [WORD_W-1:0] tail_data;
    logic tail_valid;
    logic push;
    logic pop;

    assign in_ready = !tail_valid;
    assign push = in_valid && !tail_valid;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_data <= BITS_RST;
            out_valid <= 1'b0;
            tail_data <= BITS_RST;
            tail_valid <= 1'b0;
        end else if (pop) begin
            if (tail_valid) begin
                out_data <= tail_data;
                out_valid <= 1'b1;
                tail_valid <= push;
                if (push) begin
                    tail_data <= in_data;
                end
            end else begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_data;
                end
            end
        end else if (push) begin
            if (!out_valid) begin
                out_data <= in_data;
                out_valid <= 1'b1;
            end else begin
                tail_data <= in_data;
                tail_valid <= 1'b1;
            end
        end
    end

endmodule

/* File: src/sapreg_stage.sv */
/*
 * Eight-bit successive approximation register stage with parallel and
 * serial result, end-of-conversion flag and a two-entry result buffer.
 * Assumes the comparator and start source are synchronous to clk and
 * that the trial pattern on approx_bits settles through the DAC and
 * comparator within one clock period.
 */
`timescale 1ns/10ps

// Functional notes
// - All inputs except rst_b are taken only on the rising clock edge.
// - A low-to-high change of start_convert between edges starts a conversion.
// - Comparator input is used directly at the rising edge, with no register in front of it.
// - hold_clear clears approx_bits, serial_out and end_of_convert to zero on the rising edge; the feed-forward variant ignores it.
// - Released hold_clear with start_convert low keeps the stage waiting.
// - Each bit is tried high in turn, then kept or cleared and held.
// - One stage resolves an eight-bit word.
// - End flag rises after the lowest bit decision or shorten input high.
// - Serial output shows each bit in its decision period, highest first.
// - Serial output is low on first period, while reset, after end.
// - Feed-forward keeps serial live one cycle after end; other inhibits.
// - Feed-forward variant with end flag low and clocking has no stable resting state.
// - Feed-forward variant restarts after end while start_convert is high.
// - Shorten input ends the conversion early; lower bits are don't care.
// - End flag fed back to start restarts on the very next clock.
// - High end flag marks parallel result valid and serial word done.
module sapreg_stage
    import sapreg_pkg::*;
#(
    parameter bit FEED_FORWARD = 1'b0 // 1 selects the feed-forward variant.
) (
    input wire logic clk, // System clock, 125 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic start_convert, // Start request level.
    input wire logic hold_clear, // Synchronous clear, master-reset variant.
    input wire logic register_shorten_in, // Early end, feed-forward variant.
    input wire logic comp_in, // Comparator decision, high keeps trial.
    input wire logic result_ready, // Result consumer accepts a word.
    output logic [WORD_W-1:0] approx_bits, // Trial and result bits to DAC.
    output logic serial_out, // Serial result, highest bit first.
    output logic end_of_convert, // High while result is complete.
    output logic [WORD_W-1:0] result_data, // Buffered result word.
    output logic result_valid // Buffered result available.
);

    ////////////////////////////////////////////////////////////////////////
    // Input sampling and start detection.
    ////////////////////////////////////////////////////////////////////////

    sapreg_state_t state;
    logic [2:0] bit_idx;
    logic sc_prev;
    logic post_end;
    logic comp_bit;
    logic clear_act;
    logic sc_rise;
    logic start;
    logic finish;
    logic buf_ready;
    logic [WORD_W-1:0] next_bits;
    logic [WORD_W-1:0] idx_mask;
    logic [WORD_W-1:0] low_mask;

    // The comparator level is used only at the clock edge, never between.
    assign comp_bit = comp_in;
    assign clear_act = !FEED_FORWARD && hold_clear;
    assign sc_rise = start_convert && !sc_prev;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sc_prev <= 1'b0;
        end else begin
            sc_prev <= start_convert;
        end
    end

    // A start is held back while the buffer has no free entry, so that a
    // finished word always finds room.
    always_comb begin
        start = 1'b0;
        case (state)
            SAPREG_IDLE: begin
                start = FEED_FORWARD || start_convert;
            end
            SAPREG_CONV: begin
                start = sc_rise;
            end
            SAPREG_DONE: begin
                start = sc_rise || (FEED_FORWARD && start_convert);
            end
            default: begin
                start = 1'b0;
            end
        endcase
        start = start && buf_ready && !clear_act;
    end

    ////////////////////////////////////////////////////////////////////////
    // Approximation sequence.
    ////////////////////////////////////////////////////////////////////////

    assign idx_mask = ONE_HOT_BASE << bit_idx;
    assign low_mask = ONE_HOT_BASE << (bit_idx - 3'h1);

    // Shorten input and the lowest-bit check are ORed; either ends the word unless a clear or start edge comes.
    assign finish = (state == SAPREG_CONV) && !clear_act && !sc_rise &&
        ((bit_idx == LOW_IDX) ||
         (FEED_FORWARD && register_shorten_in));

    always_comb begin
        next_bits = approx_bits;
        if (comp_bit) begin
            next_bits = approx_bits | idx_mask;
        end else begin
            next_bits = approx_bits & ~idx_mask;
        end
        if (bit_idx != LOW_IDX) begin
            next_bits = next_bits | low_mask;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SAPREG_IDLE;
            bit_idx <= TOP_IDX;
            approx_bits <= BITS_RST;
        end else if (clear_act) begin
            state <= SAPREG_IDLE;
            bit_idx <= TOP_IDX;
            approx_bits <= BITS_RST;
        end else if (start) begin
            state <= SAPREG_CONV;
            bit_idx <= TOP_IDX;
            approx_bits <= FIRST_TRIAL;
        end else if (finish) begin
            state <= SAPREG_DONE;
            approx_bits <= next_bits;
        end else if (state == SAPREG_CONV) begin
            bit_idx <= bit_idx - 3'h1;
            approx_bits <= next_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // End flag and serial output.
    ////////////////////////////////////////////////////////////////////////

    // With one clock the flag is registered on the deciding edge, which
    // is the nearest edge to the documented falling-edge timing.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            end_of_convert <= 1'b0;
        end else if (clear_act || start) begin
            end_of_convert <= 1'b0;
        end else if (finish) begin
            end_of_convert <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            post_end <= 1'b0;
        end else begin
            post_end <= finish && !start;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_out <= 1'b0;
        end else if (clear_act || start) begin
            serial_out <= 1'b0;
        end else if (state == SAPREG_CONV) begin
            serial_out <= comp_bit;
        end else if (post_end && FEED_FORWARD) begin
            serial_out <= comp_bit;
        end else begin
            serial_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result buffer.
    ////////////////////////////////////////////////////////////////////////

    sapreg_buf u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(finish),
        .in_ready(buf_ready),
        .in_data(next_bits),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////////

    a_clear_zeroes_all:
    assert property (@(posedge clk) disable iff (!rst_b)
        clear_act |=> (approx_bits == BITS_RST) && !end_of_convert &&
            !serial_out)
    else $error("hold_clear did not clear the outputs");

    a_wait_in_reset:
    assert property (@(posedge clk) disable iff (!rst_b)
        (!FEED_FORWARD && state == SAPREG_IDLE && !start_convert)
            |=> state == SAPREG_IDLE && approx_bits == BITS_RST)
    else $error("stage left reset without start_convert");

    a_msb_trial_start:
    assert property (@(posedge clk) disable iff (!rst_b)
        start |=> state == SAPREG_CONV && approx_bits == FIRST_TRIAL &&
            !serial_out && !end_of_convert)
    else $error("start did not load the top trial bit");

    a_first_inhibit:
    assert property (@(posedge clk) disable iff (!rst_b)
        start |=> !serial_out)
    else $error("serial output not inhibited on first period");

    a_word_eight_bits:
    assert property (@(posedge clk) disable iff (!rst_b)
        (start && !FEED_FORWARD) ##1
            (state == SAPREG_CONV && !clear_act && !sc_rise)[*8]
            |=> end_of_convert)
    else $error("eight-bit conversion did not end after eight decisions");

    a_end_after_lsb:
    assert property (@(posedge clk) disable iff (!rst_b)
        (state == SAPREG_CONV && bit_idx == LOW_IDX && !clear_act &&
            !sc_rise) |=> end_of_convert && state == SAPREG_DONE)
    else $error("end flag missing after lowest bit decision");

    a_serial_follows:
    assert property (@(posedge clk) disable iff (!rst_b)
        (state == SAPREG_CONV && !clear_act && !start)
            |=> serial_out == $past(comp_in))
    else $error("serial output does not match the decided bit");

    a_mr_inhibit_end:
    assert property (@(posedge clk) disable iff (!rst_b)
        (!FEED_FORWARD && $rose(end_of_convert))
            |-> ##1 !serial_out ##1 (!serial_out || $past(start, 2)))
    else $error("serial output not inhibited after end flag");

    a_no_rest_low:
    assert property (@(posedge clk) disable iff (!rst_b)
        (state == SAPREG_IDLE && !clear_act && buf_ready &&
            (FEED_FORWARD || start_convert)) |=> state == SAPREG_CONV)
    else $error("stage rested with end flag low");

    a_auto_recirc:
    assert property (@(posedge clk) disable iff (!rst_b)
        (FEED_FORWARD && state == SAPREG_DONE && start_convert &&
            buf_ready && !clear_act) |=> state == SAPREG_CONV)
    else $error("feed-forward stage did not recirculate");

    a_shorten_ends:
    assert property (@(posedge clk) disable iff (!rst_b)
        (FEED_FORWARD && state == SAPREG_CONV && register_shorten_in &&
            !sc_rise) |=> end_of_convert)
    else $error("shorten input did not end the conversion");

    a_free_run_next:
    assert property (@(posedge clk) disable iff (!rst_b)
        (state == SAPREG_DONE && sc_rise && buf_ready && !clear_act)
            |=> state == SAPREG_CONV && approx_bits == FIRST_TRIAL)
    else $error("fed-back end flag did not restart next clock");

    a_result_holds:
    assert property (@(posedge clk) disable iff (!rst_b)
        (state == SAPREG_DONE && !start && !clear_act)
            |=> $stable(approx_bits) && end_of_convert)
    else $error("result changed while end flag high");

    a_result_pushed:
    assert property (@(posedge clk) disable iff (!rst_b)
        (finish && !result_valid) |=> result_valid &&
            result_data == approx_bits)
    else $error("finished word not delivered to the buffer");

    a_ff_ninth_bit:
    assert property (@(posedge clk) disable iff (!rst_b)
        (FEED_FORWARD && post_end && !start && !clear_act)
            |=> serial_out == $past(comp_in))
    else $error("feed-forward serial output missed the bit after end");

    a_push_has_room:
    assert property (@(posedge clk) disable iff (!rst_b)
        finish |-> buf_ready)
    else $error("finished word found the result buffer full");

    a_idle_flag_low:
    assert property (@(posedge clk) disable iff (!rst_b)
        (state == SAPREG_IDLE) |-> !end_of_convert && !serial_out)
    else $error("waiting stage shows end flag or serial data");

endmodule

/* File: testbench/sapreg_cmp.sv */
/*
 * Behavioural model of the DAC and comparator beside the stage.
 * Assumes an ideal DAC that settles within one clock period.
 */
`timescale 1ns/10ps

module sapreg_cmp
    import sapreg_pkg::*;
(
    input wire logic [WORD_W-1:0] trial, // Trial word from the stage.
    input wire logic [WORD_W-1:0] level, // Analog input as a code.
    output logic comp_out // High while the trial is not above the input.
);
    assign comp_out = (trial <= level);
endmodule

/* File: testbench/successive_approx_register_tb.sv */
/*
 * Self-checking bench for both variants of the approximation stage.
 * Assumes inputs may change on the falling edge of the clock.
 */
`timescale 1ns/10ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module successive_approx_register_tb
    import sapreg_pkg::*;
;
    logic clk, rst_b, start_drv, free_run, hold_clear, result_ready;
    logic comp_in, serial_out, end_of_convert, result_valid, drain;
    logic ff_comp, ff_eoc, ff_serial, ff_valid, ff_ready;
    logic [WORD_W-1:0] ff_data, ff_sreg;
    int ff_words;
    logic [WORD_W-1:0] level, approx_bits, result_data, ff_bits, head_word;
    int mismatches, checks_done;
    logic [WORD_W-1:0] expq[$];

    ////////////////////////////////////////////////////////////////////
    sapreg_stage #(.FEED_FORWARD(1'b0)) uut (
        .clk(clk), .rst_b(rst_b),
        .start_convert(free_run ? end_of_convert : start_drv),
        .hold_clear(hold_clear), .register_shorten_in(1'b0),
        .comp_in(comp_in), .result_ready(result_ready),
        .approx_bits(approx_bits), .serial_out(serial_out),
        .end_of_convert(end_of_convert), .result_data(result_data),
        .result_valid(result_valid)
    );
    sapreg_cmp cmp (.trial(approx_bits), .level(level), .comp_out(comp_in));

    // Free-running seven-bit first stage with its end flag fed back to start.
    sapreg_stage #(.FEED_FORWARD(1'b1)) uut_ff (
        .clk(clk), .rst_b(rst_b), .start_convert(ff_eoc),
        .hold_clear(1'b0), .register_shorten_in(ff_bits[1]),
        .comp_in(ff_comp), .result_ready(ff_ready), .approx_bits(ff_bits),
        .serial_out(ff_serial), .end_of_convert(ff_eoc),
        .result_data(ff_data), .result_valid(ff_valid)
    );
    sapreg_cmp cmp_ff (.trial(ff_bits), .level(8'hB7), .comp_out(ff_comp));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    always @(negedge clk) begin
        result_ready <= drain && ($urandom % 4 != 0);
        ff_ready <= ($urandom % 8 == 0);
    end

    always @(posedge clk) begin
        if (rst_b && result_valid === 1'b1 && result_ready === 1'b1) begin
            `CHK(expq.size() > 0, 1'b1)
            head_word = expq.pop_front();
            `CHK(result_data, head_word)
        end
        if (rst_b && ff_valid === 1'b1 && ff_ready === 1'b1) begin
            ff_words++;
            `CHK(ff_data[7:2], 6'h2D)
        end
        if ($rose(ff_eoc)) begin
            `CHK(ff_bits[7:2], 6'h2D)
            `CHK(ff_sreg[5:0], 6'h2D)
        end
        ff_sreg <= {ff_sreg[6:0], ff_serial};
    end

    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Runs a conversion for the given number of decided bits.
    task automatic run(input logic [WORD_W-1:0] thr, input int stop);
        logic [WORD_W-1:0] model, trial;
        level = thr;
        start_drv = 1'b1;
        @(negedge clk);
        start_drv = 1'b0;
        `CHK(approx_bits, 8'h80)
        `CHK(serial_out, 1'b0)
        model = 8'h00;
        for (int k = 1; k <= stop; k++) begin
            @(negedge clk);
            trial = model | (8'h80 >> (k - 1));
            if (trial <= thr) begin
                model = trial;
            end
            `CHK(serial_out, model[8-k])
            `CHK(approx_bits, k < 8 ? model | (8'h80 >> k) : model)
            `CHK(end_of_convert, k == 8)
        end
        if (stop == 8) begin
            expq.push_back(model);
            @(negedge clk);
            `CHK(serial_out, 1'b0)
            `CHK(end_of_convert, 1'b1)
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        #(2000 * CLK_PERIOD_NS);
        mismatches++;
        conclude;
    end

    initial begin
        void'($urandom(32'h8ECC));
        rst_b = 1'b0;
        start_drv = 1'b0;
        free_run = 1'b0;
        hold_clear = 1'b0;
        level = 8'h00;
        drain = 1'b1;
        result_ready = 1'b0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(approx_bits, 8'h00)
        run(8'h00, 8);
        run(8'hFF, 8);
        repeat (20) run(8'($urandom), 8);
        // A fresh start edge in mid conversion begins again.
        run(8'h5A, 3);
        run(8'hA5, 8);
        run(8'h3C, 4);
        hold_clear = 1'b1;
        @(negedge clk);
        `CHK(approx_bits, 8'h00)
        `CHK(end_of_convert, 1'b0)
        `CHK(serial_out, 1'b0)
        hold_clear = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(approx_bits, 8'h00)
        run(8'h96, 8);
        free_run = 1'b1;
        expq.push_back(8'h96);
        @(negedge clk);
        `CHK(approx_bits, 8'h80)
        `CHK(end_of_convert, 1'b0)
        free_run = 1'b0;
        repeat (9) @(negedge clk);
        for (int i = 0; i < 20 && expq.size() > 0; i++) begin
            @(negedge clk);
        end
        // Two words wait while the consumer stalls.
        drain = 1'b0;
        repeat (2) @(negedge clk);
        run(8'h11, 8);
        run(8'h22, 8);
        repeat (4) @(negedge clk);
        `CHK(result_valid, 1'b1)
        `CHK(result_data, 8'h11)
        drain = 1'b1;
        for (int i = 0; i < 40 && expq.size() > 0; i++) begin
            @(negedge clk);
        end
        @(negedge clk);
        `CHK(expq.size(), 0)
        `CHK(result_valid, 1'b0)
        `CHK(ff_words > 3, 1'b1)
        conclude;
    end
endmodule
